// >>> rtl/piso_pkg.sv
// constants and types shared by the serial shift register and its input synchroniser
// assumes one system clock; all device pins arrive asynchronously to it
`default_nettype none
package piso_pkg;
    localparam int          DATA_WIDTH      = 8;
    localparam int          CLOCK_PERIOD_NS = 100;
    localparam int          CTRL_WIDTH      = 4;
    // bit positions in the synchronised control group
    localparam int          CTRL_CLEAR_N    = 0;
    localparam int          CTRL_LOAD_N     = 1;
    localparam int          CTRL_SHIFT_CLK  = 2;
    localparam int          CTRL_STORE_CLK  = 3;
    // controls idle high after reset so that no false edge or clear is seen
    localparam logic [3:0]  CTRL_RESET      = 4'hf;
    localparam logic [8:0]  DATA_RESET      = 9'h000;
    localparam logic [7:0]  SHIFT_RESET     = 8'h00;

    typedef enum logic [3:0] {
        MODE_SHIFT    = 4'h1,
        MODE_LOAD     = 4'h2,
        MODE_CLEAR    = 4'h4,
        MODE_CONFLICT = 4'h8
    } mode_t;
endpackage
`default_nettype wire

// >>> rtl/pin_sync.sv
// two-flop synchroniser with rising-edge detect for a group of pins
// assumes pins are asynchronous to i_clock and change slower than the clock
`default_nettype none
module pin_sync #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_level,
    output logic      [WIDTH-1:0] o_rise
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] prev_reg;

    if (WIDTH < 1) begin : g_check
        $error("pin_sync needs at least one bit");
    end

    // meta_reg feeds sync_reg only
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= RESET_VALUE;
            sync_reg <= RESET_VALUE;
            prev_reg <= RESET_VALUE;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign o_level = sync_reg;
    assign o_rise  = sync_reg & ~prev_reg;
endmodule
`default_nettype wire

// >>> rtl/piso_shift_register_with_storage.sv
// eight-bit storage register feeding an eight-bit parallel/serial-in shift register
// assumes every pin is asynchronous; pin clocks are sampled, not used as clocks
`default_nettype none
module piso_shift_register_with_storage #(
    parameter int DATA_WIDTH = piso_pkg::DATA_WIDTH
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_rst,
    input  wire logic [DATA_WIDTH-1:0] i_parallel_data,
    input  wire logic                  i_serial_data,
    input  wire logic                  i_storage_clock,
    input  wire logic                  i_shift_clock,
    input  wire logic                  i_parallel_load_n,
    input  wire logic                  i_master_clear_n,
    output logic                       o_serial_out,
    output logic                       o_load_clear_conflict
);
    if (DATA_WIDTH != piso_pkg::DATA_WIDTH) begin : g_check
        $error("data width must match the package constant");
    end

    logic [DATA_WIDTH:0]            data_level;
    logic [piso_pkg::CTRL_WIDTH-1:0] ctrl_level;
    logic [piso_pkg::CTRL_WIDTH-1:0] ctrl_rise;
    logic [DATA_WIDTH-1:0]          data_s;
    logic                           serial_s;
    logic                           store_rise;
    logic                           shift_rise;
    logic                           load_act;
    logic                           clr_act;
    logic [DATA_WIDTH-1:0]          storage_reg;
    logic [DATA_WIDTH-1:0]          storage_next;
    logic [DATA_WIDTH-1:0]          shift_reg;
    logic [DATA_WIDTH-1:0]          shift_next;
    logic [DATA_WIDTH-1:0]          shifted;
    logic [DATA_WIDTH-1:0]          load_value;
    piso_pkg::mode_t                mode_next;
    logic                           serial_out_reg;
    logic                           conflict_reg;

    // data and controls pass equal sync depth, so their relative timing is kept
    pin_sync #(
        .WIDTH       (DATA_WIDTH + 1),
        .RESET_VALUE (piso_pkg::DATA_RESET)
    ) u_data_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async ({i_serial_data, i_parallel_data}),
        .o_level (data_level),
        .o_rise  ()
    );

    pin_sync #(
        .WIDTH       (piso_pkg::CTRL_WIDTH),
        .RESET_VALUE (piso_pkg::CTRL_RESET)
    ) u_ctrl_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async ({i_storage_clock, i_shift_clock, i_parallel_load_n, i_master_clear_n}),
        .o_level (ctrl_level),
        .o_rise  (ctrl_rise)
    );

    assign data_s     = data_level[DATA_WIDTH-1:0];
    assign serial_s   = data_level[DATA_WIDTH];
    assign store_rise = ctrl_rise[piso_pkg::CTRL_STORE_CLK];
    assign shift_rise = ctrl_rise[piso_pkg::CTRL_SHIFT_CLK];
    assign load_act   = ~ctrl_level[piso_pkg::CTRL_LOAD_N];
    assign clr_act    = ~ctrl_level[piso_pkg::CTRL_CLEAR_N];

    // mode decode from the active-low control pins
    assign mode_next = (load_act && clr_act) ? piso_pkg::MODE_CONFLICT :
                       load_act              ? piso_pkg::MODE_LOAD :
                       clr_act               ? piso_pkg::MODE_CLEAR :
                                               piso_pkg::MODE_SHIFT;

    assign storage_next = store_rise ? data_s : storage_reg;
    // a storage edge during a load passes fresh inputs straight through to the shifter
    assign load_value   = store_rise ? data_s : storage_reg;
    assign shifted      = shift_rise ? {shift_reg[DATA_WIDTH-2:0], serial_s}
                                     : shift_reg;

    always_comb begin
        shift_next = shift_reg;
        case (mode_next)
            piso_pkg::MODE_SHIFT:    shift_next = shifted;
            piso_pkg::MODE_LOAD:     shift_next = load_value;
            piso_pkg::MODE_CLEAR:    shift_next = piso_pkg::SHIFT_RESET;
            // undefined combination: contents simply hold, which is one legal outcome
            piso_pkg::MODE_CONFLICT: shift_next = shift_reg;
            default:                 shift_next = shift_reg;
        endcase
    end

    // storage register has no reset of its own, as on the pins
    always_ff @(posedge i_clock) begin
        storage_reg <= storage_next;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            shift_reg <= piso_pkg::SHIFT_RESET;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // serial output flop mirrors the last stage and the conflict flag is registered too, so both pins come straight from a flop
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            serial_out_reg <= 1'b0;
            conflict_reg   <= 1'b0;
        end else begin
            serial_out_reg <= shift_next[DATA_WIDTH-1];
            conflict_reg   <= (mode_next == piso_pkg::MODE_CONFLICT);
        end
    end

    assign o_serial_out          = serial_out_reg;
    assign o_load_clear_conflict = conflict_reg;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence load_held_s;
        load_act && !clr_act && !store_rise;
    endsequence

    sequence idle_shift_s;
        !load_act && !clr_act && shift_rise;
    endsequence

    // shift edge that a held load must swallow
    sequence load_shift_s;
        load_act && !clr_act && !store_rise && shift_rise;
    endsequence

    sequence clear_store_s;
        clr_act && !load_act && store_rise;
    endsequence

    sequence idle_hold_s;
        !load_act && !clr_act && !shift_rise;
    endsequence

    // both pin clocks see the same two-flop delay, so their order is kept
    pin_latency_a: assert property ($rose(i_shift_clock) |-> ##2 shift_rise)
        else $error("shift clock pin edge not seen two cycles later");

    store_latency_a: assert property ($rose(i_storage_clock) |-> ##2 store_rise)
        else $error("storage clock pin edge not seen two cycles later");

    // a pin clock held high must not act twice
    single_shift_a: assert property (shift_rise |=> !shift_rise)
        else $error("one shift clock edge acted twice");

    single_store_a: assert property (store_rise |=> !store_rise)
        else $error("one storage clock edge acted twice");

    store_capture_a: assert property (store_rise |=> storage_reg == $past(data_s))
        else $error("storage register missed parallel inputs");

    load_through_a: assert property (
        store_rise && load_act && !clr_act |=> shift_reg == $past(data_s))
        else $error("storage edge during load did not reach shifter");

    load_copy_a: assert property (load_held_s |=> shift_reg == $past(storage_reg))
        else $error("load did not copy storage register");

    load_over_shift_a: assert property (
        load_shift_s |=> shift_reg == $past(storage_reg))
        else $error("shift clock acted while load held");

    clear_zero_a: assert property (
        clr_act && !load_act |=> shift_reg == piso_pkg::SHIFT_RESET)
        else $error("clear did not zero the shifter");

    // storage keeps capturing while the shifter is held clear
    clear_store_a: assert property (
        clear_store_s |=> shift_reg == piso_pkg::SHIFT_RESET && storage_reg == $past(data_s))
        else $error("storage edge during clear disturbed the registers");

    shift_step_a: assert property (
        idle_shift_s |=> shift_reg == {$past(shift_reg[DATA_WIDTH-2:0]), $past(serial_s)})
        else $error("shift step wrong");

    shift_hold_a: assert property (idle_hold_s |=> $stable(shift_reg))
        else $error("shifter moved without a shift clock edge");

    // load copies every cycle, so a stray shift would show as a change
    load_blocks_a: assert property (load_held_s ##1 load_held_s |=> $stable(shift_reg))
        else $error("shifter moved while load held");

    // output flop and last stage load from the same next value
    serial_follow_a: assert property (o_serial_out == shift_reg[DATA_WIDTH-1])
        else $error("serial output differs from last stage");

    serial_tap_a: assert property (
        idle_shift_s |=> o_serial_out == $past(shift_reg[DATA_WIDTH-2]))
        else $error("serial output not last stage");

    conflict_flag_a: assert property (
        load_act && clr_act |=> o_load_clear_conflict && $stable(shift_reg))
        else $error("conflict not flagged or shifter changed");

    conflict_idle_a: assert property (
        !(load_act && clr_act) |=> !o_load_clear_conflict)
        else $error("conflict flag raised without conflict");
endmodule
`default_nettype wire

// >>> dv/piso_host_model.sv
// host logic that drives the pins of the serial shift register
// assumes pins are sampled by i_clock, so every pulse lasts two clock periods
// assumes one request at a time: i_req stands until o_done answers it
`default_nettype none
module piso_host_model (
    input  wire logic       i_clock,
    input  wire logic       i_req,
    input  wire logic [1:0] i_op,
    input  wire logic [7:0] i_arg,
    output logic            o_done,
    output logic      [7:0] o_parallel_data,
    output logic            o_serial_data,
    output logic            o_storage_clock,
    output logic            o_shift_clock,
    output logic            o_parallel_load_n,
    output logic            o_master_clear_n
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [1:0] OP_STORE = 2'h0;
    localparam logic [1:0] OP_SHIFT = 2'h1;
    localparam logic [1:0] OP_LEVEL = 2'h2;
    initial begin
        o_done            = 1'b0;
        o_parallel_data   = 8'h00;
        o_serial_data     = 1'b0;
        o_storage_clock   = 1'b0;
        o_shift_clock     = 1'b0;
        o_parallel_load_n = 1'b1;
        o_master_clear_n  = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    // data leads the clock rise by one sample, as the pins need
    task automatic store(input logic [7:0] d);
        o_parallel_data = d;
        step(1);
        o_storage_clock = 1'b1;
        step(2);
        o_storage_clock = 1'b0;
        step(2);
    endtask
    task automatic shift(input logic b);
        o_serial_data = b;
        step(1);
        o_shift_clock = 1'b1;
        step(2);
        o_shift_clock = 1'b0;
        step(2);
    endtask
    // callers never pass both low: load and clear together is undefined
    task automatic level(input logic load_n, input logic clear_n);
        o_parallel_load_n = load_n;
        o_master_clear_n  = clear_n;
        step(4);
    endtask
    // one pin operation per request; done stands until the request drops
    always begin
        @(posedge i_clock);
        if (i_req && !o_done) begin
            #1;
            case (i_op)
                OP_STORE: store(i_arg);
                OP_SHIFT: shift(i_arg[0]);
                OP_LEVEL: level(i_arg[1], i_arg[0]);
                default:  step(1);
            endcase
            o_done = 1'b1;
            wait (!i_req);
            o_done = 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> dv/piso_shift_register_with_storage_test.sv
// self-checking bench for the serial shift register with input storage
// assumes the host model drives all pins but clock and reset, and the design answers in three cycles
`default_nettype none
module piso_shift_register_with_storage_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock, rst, sdata, sclk, hclk, load_n, clear_n, sout, conflict;
    logic       req, done;
    logic [1:0] op;
    logic [7:0] pdata, arg;
    int         fails, n_checks, cycles;
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    piso_host_model i_piso_host_model (.i_clock(clock), .i_req(req), .i_op(op), .i_arg(arg),
        .o_done(done), .o_parallel_data(pdata), .o_serial_data(sdata),
        .o_storage_clock(sclk), .o_shift_clock(hclk), .o_parallel_load_n(load_n),
        .o_master_clear_n(clear_n));
    piso_shift_register_with_storage i_piso_shift_register_with_storage (.i_clock(clock),
        .i_rst(rst), .i_parallel_data(pdata), .i_serial_data(sdata),
        .i_storage_clock(sclk), .i_shift_clock(hclk), .i_parallel_load_n(load_n),
        .i_master_clear_n(clear_n), .o_serial_out(sout), .o_load_clear_conflict(conflict));
    task automatic tally_and_finish();
        if (fails == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    // one host request: held until done is seen at an edge, then an edge passes
    task automatic host(input logic [1:0] code, input logic [7:0] value);
        op  = code;
        arg = value;
        req = 1'b1;
        @(posedge clock);
        while (!done) @(posedge clock);
        #1 req = 1'b0;
        @(posedge clock);
        #1;
    endtask
    task automatic store(input logic [7:0] d);
        host(2'h0, d);
    endtask
    task automatic shift(input logic b);
        host(2'h1, {7'h00, b});
    endtask
    task automatic level(input logic ld_n, input logic clr_n);
        host(2'h2, {6'h00, ld_n, clr_n});
    endtask
    // first bit out is stage 7; serial input bits are fed msb first
    task automatic shift_out(input logic [7:0] exp, input logic [7:0] sin);
        for (int i = 7; i >= 0; i--) begin
            chk("serial_out", exp[i], sout);
            shift(sin[i]);
        end
    endtask
    task automatic t_capture_then_load();
        store(8'ha5);
        level(1'b0, 1'b1);
        chk("load_copy", 1'b1, sout);
        level(1'b1, 1'b1);
        shift_out(8'ha5, 8'h96);
        shift_out(8'h96, 8'h00);
    endtask
    task automatic t_store_during_load();
        level(1'b0, 1'b1);
        store(8'h3c);
        chk("store_in_load", 1'b0, sout);
        shift(1'b1);
        chk("shift_in_load", 1'b0, sout);
        level(1'b1, 1'b1);
        shift_out(8'h3c, 8'h00);
    endtask
    task automatic t_clear();
        store(8'hff);
        level(1'b0, 1'b1);
        level(1'b1, 1'b1);
        chk("before_clear", 1'b1, sout);
        level(1'b1, 1'b0);
        chk("cleared", 1'b0, sout);
        shift(1'b1);
        store(8'h01);
        chk("clear_holds", 1'b0, sout);
        level(1'b1, 1'b1);
        shift_out(8'h00, 8'h00);
        level(1'b0, 1'b1);
        chk("store_in_clear", 1'b0, sout);
        level(1'b1, 1'b1);
        shift_out(8'h01, 8'h00);
        chk("conflict", 1'b0, conflict);
    endtask
    // reset clears the shifter but leaves the unreset storage word in place
    task automatic t_mid_reset();
        store(8'h81);
        level(1'b0, 1'b1);
        level(1'b1, 1'b1);
        chk("before_reset", 1'b1, sout);
        rst = 1'b1;
        repeat (3) @(posedge clock);
        #1 rst = 1'b0;
        chk("reset_clears", 1'b0, sout);
        repeat (2) @(posedge clock);
        #1;
        level(1'b0, 1'b1);
        chk("storage_kept", 1'b1, sout);
        level(1'b1, 1'b1);
        shift_out(8'h81, 8'h00);
    endtask
    // the whole run needs about 550 cycles; the ceiling leaves a wide margin
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        fails = 0;
        n_checks = 0;
        cycles = 0;
        req = 1'b0;
        op = 2'h0;
        arg = 8'h00;
        rst = 1'b1;
        repeat (3) @(posedge clock);
        #1 rst = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        t_capture_then_load();
        t_store_during_load();
        t_clear();
        t_mid_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
